// [design/tfc_defines.vh]
// Purpose: constants shared by the timer flag control block
// Assumes: byte-wide register port, printed byte offsets
// Notes: offsets are byte addresses on the plain register port
`ifndef TFC_DEFINES_VH
`define TFC_DEFINES_VH

`define TFC_OFF_CTRL 8'h12
`define TFC_OFF_STATUS 8'h13
`define TFC_OFF_CAP_HI 8'h14
`define TFC_OFF_CAP_LO 8'h15
`define TFC_OFF_CMP_HI 8'h16
`define TFC_OFF_CMP_LO 8'h17
`define TFC_OFF_CNT_HI 8'h18
`define TFC_OFF_CNT_LO 8'h19
`define TFC_OFF_ALT_HI 8'h1A
`define TFC_OFF_ALT_LO 8'h1B

`define TFC_BIT_CAP 7
`define TFC_BIT_CMP 6
`define TFC_BIT_OVF 5
`define TFC_BIT_EDGE 1

`define TFC_CNT_RESET 16'hFFFC
`define TFC_CNT_TOP 16'hFFFF
`define TFC_PRESCALE 8'h04

`endif

// [design/tfc_edge_sync.v]
// Purpose: synchronise the capture pin and detect the selected edge
// Assumes: pin is asynchronous to clock
// Notes: edges are suppressed until the synchroniser has settled
`timescale 1ns/1ps
module tfc_edge_sync (
  input wire clock,
  input wire arst_n,
  input wire pin,
  input wire rising_sel,
  output wire edge_pulse
);
  reg sync1;
  reg sync2;
  reg sync3;
  reg [1:0] settle;

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
      settle <= 2'h0;
    end else begin
      sync1 <= pin;
      sync2 <= sync1;
      sync3 <= sync2;
      if (settle != 2'h3) begin
        settle <= settle + 2'h1;
      end
    end
  end

  // reset values of the chain must not look like an edge
  assign edge_pulse = (settle == 2'h3) &
                      (rising_sel ? (sync2 & ~sync3) : (~sync2 & sync3));
endmodule

// [design/tfc_top.v]
// Purpose: flag, enable and counter control of a 16-bit capture/compare timer
// Assumes: arst_n is the external reset; por_arst_n is low at power-up only
// Notes: stop_mode is a level from the core, same clock domain
`timescale 1ns/1ps
`include "tfc_defines.vh"
module tfc_top #(
  parameter [7:0] PRESCALE = `TFC_PRESCALE
) (
  input wire clock,
  input wire arst_n,
  input wire por_arst_n,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata,
  input wire capture_input,
  input wire stop_mode,
  output reg irq
);
  localparam [7:0] PRESC_LAST = PRESCALE - 8'h01;

  function hit;
    input [7:0] a;
    input [7:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  reg [7:0] presc;
  reg [15:0] cnt;
  reg capture_irq_enable;
  reg compare_irq_enable;
  reg overflow_irq_enable;
  reg capture_edge_select;
  reg capture_flag;
  reg compare_flag;
  reg overflow_flag;
  reg arm_cap;
  reg arm_cmp;
  reg arm_ovf;
  reg [15:0] cap_val;
  reg cap_hold;
  reg [15:0] cmp_val;
  reg cmp_inhibit;
  reg [7:0] cnt_low_buf;
  reg cnt_latched;
  reg [7:0] alt_low_buf;
  reg alt_latched;
  reg stop_armed;
  reg [15:0] stop_val;
  reg stop_d;
  reg [7:0] next_rdata;

  wire edge_pulse;
  wire tick;
  wire [15:0] cnt_inc;
  wire wake;
  wire cap_live;
  wire cap_evt;
  wire cmp_evt;
  wire ovf_evt;
  wire rd_stat;
  wire rd_cap_hi;
  wire rd_cap_lo;
  wire cmp_lo_acc;
  wire cnt_lo_acc;
  wire rd_cnt_hi;
  wire rd_alt_hi;
  wire rd_alt_lo;
  wire wr_ctl;
  wire wr_cmp_hi;
  wire wr_cmp_lo;

  tfc_edge_sync tfc_edge_sync_i (
    .clock(clock),
    .arst_n(arst_n),
    .pin(capture_input),
    .rising_sel(capture_edge_select),
    .edge_pulse(edge_pulse)
  );

  assign rd_stat = rd & hit(addr, `TFC_OFF_STATUS);
  assign rd_cap_hi = rd & hit(addr, `TFC_OFF_CAP_HI);
  assign rd_cap_lo = rd & hit(addr, `TFC_OFF_CAP_LO);
  assign cmp_lo_acc = (rd | wr) & hit(addr, `TFC_OFF_CMP_LO);
  assign cnt_lo_acc = (rd | wr) & hit(addr, `TFC_OFF_CNT_LO);
  assign rd_cnt_hi = rd & hit(addr, `TFC_OFF_CNT_HI);
  assign rd_alt_hi = rd & hit(addr, `TFC_OFF_ALT_HI);
  assign rd_alt_lo = rd & hit(addr, `TFC_OFF_ALT_LO);
  assign wr_ctl = wr & hit(addr, `TFC_OFF_CTRL);
  assign wr_cmp_hi = wr & hit(addr, `TFC_OFF_CMP_HI);
  assign wr_cmp_lo = wr & hit(addr, `TFC_OFF_CMP_LO);

  // the prescaler freezes with the counter while stopped
  assign tick = (presc == PRESC_LAST) & ~stop_mode;
  assign cnt_inc = cnt + 16'h0001;
  assign wake = stop_d & ~stop_mode;

  // a held capture high byte blocks live transfers until the low byte is read; the stop wake transfer is not blocked
  assign cap_live = edge_pulse & ~stop_mode & ~cap_hold;
  assign cap_evt = cap_live | (wake & stop_armed);
  assign cmp_evt = tick & ~cmp_inhibit & (cnt_inc == cmp_val);
  assign ovf_evt = tick & (cnt == `TFC_CNT_TOP);

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      presc <= 8'h00;
    end else if (!stop_mode) begin
      if (presc == PRESC_LAST) begin
        presc <= 8'h00;
      end else begin
        presc <= presc + 8'h01;
      end
    end
  end

  // external reset presets; stop exit by pin resumes from the held count
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= `TFC_CNT_RESET;
    end else if (tick) begin
      cnt <= cnt_inc;
    end
  end

  // enables are cleared by external reset only
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      capture_irq_enable <= 1'b0;
      compare_irq_enable <= 1'b0;
      overflow_irq_enable <= 1'b0;
    end else if (wr_ctl) begin
      capture_irq_enable <= wdata[`TFC_BIT_CAP];
      compare_irq_enable <= wdata[`TFC_BIT_CMP];
      overflow_irq_enable <= wdata[`TFC_BIT_OVF];
    end
  end

  // edge select only sees power-on reset, external reset leaves it
  always @(posedge clock or negedge por_arst_n) begin
    if (!por_arst_n) begin
      capture_edge_select <= 1'b0;
    end else if (wr_ctl) begin
      capture_edge_select <= wdata[`TFC_BIT_EDGE];
    end
  end

  // flags survive external reset; a set in the clearing cycle wins
  always @(posedge clock or negedge por_arst_n) begin
    if (!por_arst_n) begin
      capture_flag <= 1'b0;
      compare_flag <= 1'b0;
      overflow_flag <= 1'b0;
    end else begin
      capture_flag <= cap_evt | (capture_flag & ~(arm_cap & rd_cap_lo));
      compare_flag <= cmp_evt | (compare_flag & ~(arm_cmp & cmp_lo_acc));
      overflow_flag <= ovf_evt | (overflow_flag & ~(arm_ovf & cnt_lo_acc));
    end
  end

  // a status read arms clearing only for flags it saw set
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      arm_cap <= 1'b0;
      arm_cmp <= 1'b0;
      arm_ovf <= 1'b0;
    end else if (rd_stat) begin
      arm_cap <= capture_flag;
      arm_cmp <= compare_flag;
      arm_ovf <= overflow_flag;
    end else begin
      if (rd_cap_lo) begin
        arm_cap <= 1'b0;
      end
      if (cmp_lo_acc) begin
        arm_cmp <= 1'b0;
      end
      if (cnt_lo_acc) begin
        arm_ovf <= 1'b0;
      end
    end
  end

  // capture in stop: remember the first edge only, no flag yet
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      stop_armed <= 1'b0;
      stop_val <= 16'h0000;
      stop_d <= 1'b0;
    end else begin
      stop_d <= stop_mode;
      if (stop_mode & edge_pulse & ~stop_armed) begin
        stop_armed <= 1'b1;
        stop_val <= cnt;
      end else if (wake) begin
        stop_armed <= 1'b0;
      end
    end
  end

  // capture data is kept over external reset
  always @(posedge clock or negedge por_arst_n) begin
    if (!por_arst_n) begin
      cap_val <= 16'h0000;
    end else if (cap_live) begin
      cap_val <= cnt;
    end else if (wake & stop_armed) begin
      cap_val <= stop_val;
    end
  end

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cap_hold <= 1'b0;
    end else if (rd_cap_hi) begin
      cap_hold <= 1'b1;
    end else if (rd_cap_lo) begin
      cap_hold <= 1'b0;
    end
  end

  always @(posedge clock or negedge por_arst_n) begin
    if (!por_arst_n) begin
      cmp_val <= 16'h0000;
    end else begin
      if (wr_cmp_hi) begin
        cmp_val[15:8] <= wdata;
      end
      if (wr_cmp_lo) begin
        cmp_val[7:0] <= wdata;
      end
    end
  end

  // after a high byte write the compare cannot match until the low byte is written
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cmp_inhibit <= 1'b0;
    end else if (wr_cmp_hi) begin
      cmp_inhibit <= 1'b1;
    end else if (wr_cmp_lo) begin
      cmp_inhibit <= 1'b0;
    end
  end

  // reading a high byte freezes the low byte for a coherent pair
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt_low_buf <= 8'h00;
      cnt_latched <= 1'b0;
    end else if (rd_cnt_hi & ~cnt_latched) begin
      cnt_low_buf <= cnt[7:0];
      cnt_latched <= 1'b1;
    end else if (cnt_lo_acc & rd) begin
      cnt_latched <= 1'b0;
    end
  end

  // alternate view: same latch, but no effect on the overflow flag
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      alt_low_buf <= 8'h00;
      alt_latched <= 1'b0;
    end else if (rd_alt_hi & ~alt_latched) begin
      alt_low_buf <= cnt[7:0];
      alt_latched <= 1'b1;
    end else if (rd_alt_lo) begin
      alt_latched <= 1'b0;
    end
  end

  always @* begin
    next_rdata = 8'h00;
    case (addr)
      `TFC_OFF_CTRL: begin
        next_rdata[`TFC_BIT_CAP] = capture_irq_enable;
        next_rdata[`TFC_BIT_CMP] = compare_irq_enable;
        next_rdata[`TFC_BIT_OVF] = overflow_irq_enable;
        next_rdata[`TFC_BIT_EDGE] = capture_edge_select;
      end
      `TFC_OFF_STATUS: begin
        next_rdata[`TFC_BIT_CAP] = capture_flag;
        next_rdata[`TFC_BIT_CMP] = compare_flag;
        next_rdata[`TFC_BIT_OVF] = overflow_flag;
      end
      `TFC_OFF_CAP_HI: begin
        next_rdata = cap_val[15:8];
      end
      `TFC_OFF_CAP_LO: begin
        next_rdata = cap_val[7:0];
      end
      `TFC_OFF_CMP_HI: begin
        next_rdata = cmp_val[15:8];
      end
      `TFC_OFF_CMP_LO: begin
        next_rdata = cmp_val[7:0];
      end
      `TFC_OFF_CNT_HI: begin
        next_rdata = cnt[15:8];
      end
      `TFC_OFF_CNT_LO: begin
        next_rdata = cnt_latched ? cnt_low_buf : cnt[7:0];
      end
      `TFC_OFF_ALT_HI: begin
        next_rdata = cnt[15:8];
      end
      `TFC_OFF_ALT_LO: begin
        next_rdata = alt_latched ? alt_low_buf : cnt[7:0];
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
  end

  // data stands only in the cycle after the read strobe
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 8'h00;
    end else if (rd) begin
      rdata <= next_rdata;
    end else begin
      rdata <= 8'h00;
    end
  end

  // status writes decode nowhere, so flags cannot be forced

  // level request; also the wake source while the core waits
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= (capture_flag & capture_irq_enable) |
             (compare_flag & compare_irq_enable) |
             (overflow_flag & overflow_irq_enable);
    end
  end
endmodule

// [test/tfc_host_model.sv]
// Purpose: host core model driving the register port
// Assumes: one strobe per cycle, read data one cycle later
// Notes: a gap cycle follows every access
`timescale 1ns/1ps
module tfc_host_model (
  input wire clock,
  output logic [7:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd
);
  initial begin
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    @(posedge clock);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
endmodule

// [test/tfc_top_monitor.sv]
// Purpose: port-level assertions for the timer flag control block
// Assumes: one clock domain, arst_n is the external reset
// Notes: enables and edge select are mirrored from control writes
`timescale 1ns/1ps
module tfc_top_monitor #(
  parameter [7:0] PRESCALE = 8'h04
) (
  input wire clock,
  input wire arst_n,
  input wire por_arst_n,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  input wire [7:0] rdata,
  input wire capture_input,
  input wire stop_mode,
  input wire irq
);
  logic [2:0] en;
  logic edg;
  logic rd_q;
  logic [7:0] a_q;
  wire st_rd = rd_q && a_q == 8'h13;
  wire hit = |(rdata[7:5] & en);
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      en <= 3'b000;
      rd_q <= 1'b0;
      a_q <= 8'h00;
    end else begin
      rd_q <= rd;
      a_q <= addr;
      if (wr && addr == 8'h12) en <= wdata[7:5];
    end
  end
  // edge select survives the external reset
  always @(posedge clock or negedge por_arst_n) begin
    if (!por_arst_n) edg <= 1'b0;
    else if (wr && addr == 8'h12) edg <= wdata[1];
  end
  default clocking dc @(posedge clock); endclocking
  default disable iff (!arst_n);
  chk_irq_reset: assert property ($rose(arst_n) |-> !irq)
    else $error("irq high after reset");
  chk_ctrl_mirror: assert property (
    rd_q && a_q == 8'h12 |-> rdata == {en, 3'b000, edg, 1'b0})
    else $error("control readback wrong");
  chk_status_pad: assert property (st_rd |-> rdata[4:0] == 5'h00)
    else $error("status low bits not zero");
  chk_irq_follows: assert property (st_rd && hit |-> irq)
    else $error("irq low with enabled flag");
  chk_irq_masked: assert property (st_rd && !hit |-> !irq)
    else $error("irq high without enabled flag");
  chk_rdata_idle: assert property (!rd_q |-> rdata == 8'h00)
    else $error("read data outside slot");
  chk_unmapped_zero: assert property (rd_q && a_q == 8'h00 |-> rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_stop_quiet: assert property (
    stop_mode && $past(stop_mode, 2) && $past(en, 2) == en |-> !$rose(irq))
    else $error("irq rose in stop");
  cover property ($rose(irq));
  cover property (st_rd && rdata[7]);
  cover property ($fell(stop_mode));
endmodule
bind tfc_top tfc_top_monitor #(.PRESCALE(PRESCALE)) tfc_top_monitor_i (
  .clock,
  .arst_n,
  .por_arst_n,
  .addr,
  .wdata,
  .wr,
  .rd,
  .rdata,
  .capture_input,
  .stop_mode,
  .irq
);

// [test/test_tfc_top.sv]
// Purpose: self-checking bench for the timer flag control block
// Assumes: host model drives the register port, bench drives pins
// Notes: expected reads queue up and are matched when data appears
`timescale 1ns/1ps
module test_tfc_top;
  logic clock = 1'b0;
  logic arst_n;
  logic por_arst_n;
  logic capture_input;
  logic stop_mode;
  wire [7:0] addr;
  wire [7:0] wdata;
  wire wr;
  wire rd;
  wire [7:0] rdata;
  wire irq;
  logic [15:0] exp_q[$];
  logic [15:0] e;
  logic [7:0] last;
  logic [7:0] rnd;
  logic [7:0] held;
  logic pend = 1'b0;
  int error_cnt = 0;
  int cmp_count = 0;
  always #20 clock = ~clock;
  tfc_host_model tfc_host_model_i (.clock, .addr, .wdata, .wr, .rd);
  tfc_top #(.PRESCALE(8'h04)) tfc_top_i (
    .clock,
    .arst_n,
    .por_arst_n,
    .addr,
    .wdata,
    .wr,
    .rd,
    .rdata,
    .capture_input,
    .stop_mode,
    .irq
  );
  task fail(input string m);
    error_cnt++;
    $display("CHECK FAILED t=%0t %s", $time, m);
  endtask
  task wrap_up;
    $display("errors=%0d compares=%0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task wt(input int n);
    repeat (n) @(posedge clock);
  endtask
  task host(input logic w, input logic [7:0] a, input logic [7:0] d);
    tfc_host_model_i.bus(w, a, d);
  endtask
  // mask zero means the result is only kept in last
  task rd_x(input logic [7:0] a, input logic [7:0] v, input logic [7:0] m);
    exp_q.push_back({m, v});
    host(1'b0, a, 8'h00);
  endtask
  task irq_is(input logic v);
    wt(2);
    @(negedge clock);
    cmp_count++;
    if (irq !== v) fail("interrupt level");
    // back on the rising edge so the next drive lands there
    @(posedge clock);
  endtask
  // stop is dropped while reset is low so no armed capture can land
  task ext_rst;
    arst_n <= 1'b0;
    wt(1);
    stop_mode <= 1'b0;
    wt(1);
    arst_n <= 1'b1;
  endtask
  always @(posedge clock) begin
    pend <= rd;
    if (pend) begin
      e = exp_q.pop_front();
      last = rdata;
      if (e[15:8] != 8'h00) begin
        cmp_count++;
        if ((rdata & e[15:8]) !== e[7:0]) fail("read data");
      end
    end
  end
  initial begin
    wt(3000);
    fail("timeout");
    wrap_up;
  end
  initial begin
    void'($urandom(32'h7ed326e0));
    arst_n = 1'b0;
    por_arst_n = 1'b0;
    capture_input = 1'b0;
    stop_mode = 1'b0;
    wt(10);
    arst_n <= 1'b1;
    por_arst_n <= 1'b1;
    rd_x(8'h12, 8'h00, 8'hFF);
    rd_x(8'h13, 8'h00, 8'hFF);
    rd_x(8'h00, 8'h00, 8'hFF);
    wt(4);
    rd_x(8'h13, 8'h00, 8'h60);
    wt(6);
    rd_x(8'h13, 8'h60, 8'hFF);
    host(1'b1, 8'h12, 8'hE2);
    rd_x(8'h12, 8'hE2, 8'hFF);
    irq_is(1'b1);
    ext_rst;
    rd_x(8'h12, 8'h02, 8'hFF);
    irq_is(1'b0);
    rnd = 8'($urandom);
    host(1'b1, 8'h13, rnd);
    rd_x(8'h13, 8'h60, 8'hFF);
    for (int i = 5; i < 8; i++) begin
      host(1'b1, 8'h12, 8'h01 << i);
      irq_is(i != 7);
    end
    rd_x(8'h13, 8'h60, 8'hFF);
    host(1'b1, 8'h16, 8'h80);
    host(1'b1, 8'h17, 8'h00);
    rd_x(8'h13, 8'h20, 8'hFF);
    rd_x(8'h19, 8'h00, 8'h00);
    rd_x(8'h13, 8'h00, 8'hFF);
    for (int s = 0; s < 2; s++) begin
      capture_input <= s[0];
      wt(8);
      host(1'b1, 8'h12, {6'h20, s[0], 1'b0});
      capture_input <= !s[0];
      wt(8);
      rd_x(8'h13, 8'h00, 8'h80);
      capture_input <= s[0];
      wt(4 + $urandom % 4);
      irq_is(1'b1);
      rd_x(8'h13, 8'h80, 8'h80);
      rd_x(8'h15, 8'h00, 8'h00);
      rd_x(8'h13, 8'h00, 8'h80);
    end
    stop_mode <= 1'b1;
    wt(4);
    rd_x(8'h19, 8'h00, 8'h00);
    wt(2);
    rd_x(8'h19, last, 8'hFF);
    capture_input <= 1'b0;
    wt(8);
    capture_input <= 1'b1;
    wt(8);
    // frozen counter low byte, which the armed capture must deliver
    held = last;
    rd_x(8'h13, 8'h00, 8'h80);
    irq_is(1'b0);
    stop_mode <= 1'b0;
    wt(4);
    rd_x(8'h13, 8'h80, 8'h80);
    rd_x(8'h15, held, 8'hFF);
    stop_mode <= 1'b1;
    capture_input <= 1'b0;
    wt(8);
    capture_input <= 1'b1;
    wt(8);
    ext_rst;
    rd_x(8'h19, 8'hFC, 8'hFF);
    // compare value FFFF is passed while the low byte is still pending
    host(1'b1, 8'h17, 8'hFF);
    host(1'b1, 8'h16, 8'hFF);
    wt(8);
    rd_x(8'h13, 8'h00, 8'hC0);
    host(1'b1, 8'h16, 8'h00);
    host(1'b1, 8'h17, 8'h08);
    wt(40);
    rd_x(8'h13, 8'h40, 8'h40);
    wt(2);
    wrap_up;
  end
endmodule
